// ### design/rtc_countdown_pkg.sv
// package: register map, field positions and shared types of the countdown timer
package rtc_countdown_pkg;
  // register byte offsets
  localparam logic [7:0] off_imsc = 8'h1c;
  localparam logic [7:0] off_ris = 8'h20;
  localparam logic [7:0] off_mis = 8'h24;
  localparam logic [7:0] off_icr = 8'h28;
  localparam logic [7:0] off_current_load = 8'h2c;
  localparam logic [7:0] off_control = 8'h30;
  localparam logic [7:0] off_first_load = 8'h34;
  localparam logic [7:0] off_second_load = 8'h38;
  localparam logic [7:0] off_pattern0 = 8'h3c;
  localparam logic [7:0] off_pattern1 = 8'h40;
  localparam logic [7:0] off_pattern2 = 8'h44;
  localparam logic [7:0] off_pattern3 = 8'h48;
  // control field positions
  localparam int one_shot_bit = 0;
  localparam int run_bit = 1;
  localparam int self_start_bit = 2;
  localparam int size_lo = 4;
  localparam int clk_sel_bit = 11;
  localparam int bypass_bit = 12;
  localparam logic [31:0] control_mask = 32'h00001ff7;
  // timer interrupt bit in mask, raw, masked and clear registers
  localparam int timer_irq_bit = 1;
  // reset values and bus response codes
  localparam logic [31:0] current_load_reset = 32'h0fffffff;
  localparam logic [31:0] load_reset = 32'h00000000;
  localparam logic [31:0] control_reset = 32'h00000000;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
endpackage : rtc_countdown_pkg

// ### design/rtc_countdown_timer.sv
// countdown timer of the real-time-clock unit with an AXI4-Lite register slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// bus timing: reads answer one cycle after the address is taken,
// writes two cycles after the later of address and data.
// ticks are one-cycle enables from the clock unit; the timer itself
// runs on aclk, so gating here only reports whether the count clock is wanted.
// a stopped counter keeps its value; only a load write while stopped
// preloads it, so software can resume a paused count where it left off.

module rtc_countdown_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow_tick,
  input wire logic trim_tick,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic timer_irq,
  output logic timer_clk_en
);

  typedef struct packed {
    // write channel holding flops
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    // read channel answer
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // ready flags kept as flops so the ports come straight from registers
    logic awready;
    logic wready;
    logic arready;
    // software registers
    logic [31:0] control;
    logic [31:0] first_load_value;
    logic [31:0] second_load_value;
    logic [127:0] pattern;
    // countdown state
    logic [31:0] current_load_value;
    logic [31:0] counter;
    logic [6:0] pointer;
    logic running;
    // interrupt and gating
    logic timer_raw_irq_status;
    logic timer_irq_mask;
    logic irq;
    logic clk_en;
  } state_s;

  state_s cur;
  state_s next_cur;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // load value chosen by the pattern bit under the pointer
  function automatic logic [31:0] pick_load(
    input state_s s,
    input logic [6:0] ptr);
    return s.pattern[ptr] ? s.second_load_value : s.first_load_value;
  endfunction : pick_load

  // pointer step, wrapping after the programmed pattern size
  function automatic logic [6:0] step_ptr(
    input logic [6:0] ptr,
    input logic [6:0] size);
    logic [6:0] res;
    res = (ptr + 7'h01 >= size) ? 7'h00 : 7'(ptr + 7'h01);
    return res;
  endfunction : step_ptr

  // decode and event strobes shared by the next-state logic
  logic [6:0] size;
  logic tick;
  logic do_write;
  logic do_read;
  logic load_wr;
  logic pat_wr;
  logic zero_event;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  assign size = cur.control[rtc_countdown_pkg::size_lo +: 7];
  // clock source select; ticks are single aclk-cycle enables from the unit
  assign tick = cur.control[rtc_countdown_pkg::clk_sel_bit] ? trim_tick : slow_tick;
  // a write fires once both halves are held and no answer is pending
  assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
  // a read is taken only while no earlier answer waits
  assign do_read = s_arvalid && !cur.rvalid;
  // writes that may preload or self-start the count
  assign load_wr = do_write && (cur.aw_addr == rtc_countdown_pkg::off_first_load ||
                                cur.aw_addr == rtc_countdown_pkg::off_second_load);
  // unaligned pattern offsets fall out in the register case below
  assign pat_wr = do_write && cur.aw_addr >= rtc_countdown_pkg::off_pattern0 &&
                  cur.aw_addr <= rtc_countdown_pkg::off_pattern3;
  // zero is held for one tick before the event, so the period is load plus one
  assign zero_event = tick && cur.running && cur.counter == 32'h00000000;

  // read decode; unmapped or unaligned addresses answer slverr
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    // the clear word is write-only and reads back zero
    unique case (s_araddr)
      rtc_countdown_pkg::off_imsc: rd_word[rtc_countdown_pkg::timer_irq_bit] = cur.timer_irq_mask;
      rtc_countdown_pkg::off_ris: rd_word[rtc_countdown_pkg::timer_irq_bit] = cur.timer_raw_irq_status;
      rtc_countdown_pkg::off_mis: rd_word[rtc_countdown_pkg::timer_irq_bit] = cur.irq;
      rtc_countdown_pkg::off_icr: rd_word = 32'h00000000;
      rtc_countdown_pkg::off_current_load: rd_word = cur.current_load_value;
      rtc_countdown_pkg::off_control: rd_word = cur.control;
      rtc_countdown_pkg::off_first_load: rd_word = cur.first_load_value;
      rtc_countdown_pkg::off_second_load: rd_word = cur.second_load_value;
      rtc_countdown_pkg::off_pattern0: rd_word = cur.pattern[31:0];
      rtc_countdown_pkg::off_pattern1: rd_word = cur.pattern[63:32];
      rtc_countdown_pkg::off_pattern2: rd_word = cur.pattern[95:64];
      rtc_countdown_pkg::off_pattern3: rd_word = cur.pattern[127:96];
      default: rd_ok = 1'b0;
    endcase
  end

  // writable offsets; the current load value is read-only and refuses writes
  always_comb begin
    unique case (cur.aw_addr)
      rtc_countdown_pkg::off_imsc,
      rtc_countdown_pkg::off_icr,
      rtc_countdown_pkg::off_control,
      rtc_countdown_pkg::off_first_load,
      rtc_countdown_pkg::off_second_load,
      rtc_countdown_pkg::off_pattern0,
      rtc_countdown_pkg::off_pattern1,
      rtc_countdown_pkg::off_pattern2,
      rtc_countdown_pkg::off_pattern3: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // next-state logic: bus channels, registers and the countdown
  always_comb begin
    next_cur = cur;
    // address and data accepted independently, one write at a time
    if (s_awvalid && !cur.aw_held) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_awaddr;
    end
    if (s_wvalid && !cur.w_held) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_wdata;
      next_cur.w_strb = s_wstrb;
    end
    // write answer retires on the bready handshake and reopens both channels
    if (cur.bvalid && s_bready) begin
      next_cur.bvalid = 1'b0;
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
    end
    // read answer retires on the rready handshake
    if (cur.rvalid && s_rready) begin
      next_cur.rvalid = 1'b0;
    end
    // capture read data in the cycle the address is taken
    if (do_read) begin
      next_cur.rvalid = 1'b1;
      next_cur.rdata = rd_word;
      next_cur.rresp = rd_ok ? rtc_countdown_pkg::resp_okay : rtc_countdown_pkg::resp_slverr;
    end

    // countdown: frozen when stopped, reload or stop at zero
    if (tick) begin
      next_cur.running = cur.control[rtc_countdown_pkg::run_bit];
      if (cur.running) begin
        if (cur.counter == 32'h00000000) begin
          if (cur.control[rtc_countdown_pkg::one_shot_bit]) begin
            // one-shot: stop and drop the run bit so software sees it
            next_cur.running = 1'b0;
            next_cur.control[rtc_countdown_pkg::run_bit] = 1'b0;
          end else begin
            // periodic: reload from the value the pattern picks
            next_cur.counter = pick_load(cur, cur.pointer);
            next_cur.current_load_value = pick_load(cur, cur.pointer);
            next_cur.pointer = step_ptr(cur.pointer, size);
          end
        end else begin
          next_cur.counter = cur.counter - 32'h00000001;
        end
      end else begin
        // stopped: a frozen count resumes where it paused
        next_cur.counter = cur.counter;
      end
    end

    if (do_write) begin
      // answer the write; unmapped offsets are refused with slverr
      next_cur.bvalid = 1'b1;
      next_cur.bresp = wr_ok ? rtc_countdown_pkg::resp_okay : rtc_countdown_pkg::resp_slverr;
      // register update, byte lanes honoured
      unique case (cur.aw_addr)
        rtc_countdown_pkg::off_imsc: begin
          if (cur.w_strb[0]) begin
            next_cur.timer_irq_mask = cur.w_data[rtc_countdown_pkg::timer_irq_bit];
          end
        end
        rtc_countdown_pkg::off_control: begin
          // reserved bits stay zero; a same-cycle hardware run-bit clear is overwritten by this write and by a self-start set
          next_cur.control = merge(cur.control, cur.w_data, cur.w_strb) & rtc_countdown_pkg::control_mask;
        end
        rtc_countdown_pkg::off_first_load: begin
          next_cur.first_load_value = merge(cur.first_load_value, cur.w_data, cur.w_strb);
        end
        rtc_countdown_pkg::off_second_load: begin
          next_cur.second_load_value = merge(cur.second_load_value, cur.w_data, cur.w_strb);
        end
        rtc_countdown_pkg::off_pattern0: begin
          next_cur.pattern[31:0] = merge(cur.pattern[31:0], cur.w_data, cur.w_strb);
        end
        rtc_countdown_pkg::off_pattern1: begin
          next_cur.pattern[63:32] = merge(cur.pattern[63:32], cur.w_data, cur.w_strb);
        end
        rtc_countdown_pkg::off_pattern2: begin
          next_cur.pattern[95:64] = merge(cur.pattern[95:64], cur.w_data, cur.w_strb);
        end
        rtc_countdown_pkg::off_pattern3: begin
          next_cur.pattern[127:96] = merge(cur.pattern[127:96], cur.w_data, cur.w_strb);
        end
        default: begin
        end
      endcase
      // load write while stopped: preload from the first selected value and start
      if (load_wr && !cur.running && !cur.control[rtc_countdown_pkg::run_bit]) begin
        next_cur.control[rtc_countdown_pkg::run_bit] = 1'b1;
        next_cur.pointer = 7'h00;
        next_cur.counter = pick_load(next_cur, 7'h00);
        next_cur.current_load_value = pick_load(next_cur, 7'h00);
        next_cur.pointer = step_ptr(7'h00, size);
      end
      // self-start: any load or pattern write sets the run bit; a paused count resumes, it is not reloaded here
      if ((load_wr || pat_wr) && cur.control[rtc_countdown_pkg::self_start_bit]) begin
        next_cur.control[rtc_countdown_pkg::run_bit] = 1'b1;
      end
    end

    // raw status: set wins over a same-cycle clear
    if (do_write && cur.aw_addr == rtc_countdown_pkg::off_icr && cur.w_strb[0] &&
        cur.w_data[rtc_countdown_pkg::timer_irq_bit]) begin
      next_cur.timer_raw_irq_status = 1'b0;
    end
    if (zero_event) begin
      next_cur.timer_raw_irq_status = 1'b1;
    end
    // masked interrupt registered so the pin never glitches
    next_cur.irq = next_cur.timer_raw_irq_status && next_cur.timer_irq_mask;
    // readies follow the holding flops one cycle ahead, so they leave a register
    next_cur.awready = !next_cur.aw_held;
    next_cur.wready = !next_cur.w_held;
    next_cur.arready = !next_cur.rvalid;
    // gating: clock enabled while the run bit or the running flag is set, or when bypassed
    next_cur.clk_en = next_cur.control[rtc_countdown_pkg::bypass_bit] ||
                      next_cur.control[rtc_countdown_pkg::run_bit] || next_cur.running;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      // readies come up high in reset so the first request is taken at once
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
      cur.control <= rtc_countdown_pkg::control_reset;
      cur.first_load_value <= rtc_countdown_pkg::load_reset;
      cur.second_load_value <= rtc_countdown_pkg::load_reset;
      cur.current_load_value <= rtc_countdown_pkg::current_load_reset;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state flops
  assign s_awready = cur.awready;
  assign s_wready = cur.wready;
  assign s_bvalid = cur.bvalid;
  assign s_bresp = cur.bresp;
  assign s_arready = cur.arready;
  assign s_rvalid = cur.rvalid;
  assign s_rdata = cur.rdata;
  assign s_rresp = cur.rresp;
  assign timer_irq = cur.irq;
  assign timer_clk_en = cur.clk_en;

endmodule : rtc_countdown_timer
`default_nettype wire

// ### verif/rtc_countdown_timer_monitor.sv
// checker: bus handshake and read-answer relations of the countdown timer
`timescale 1ns/1ps
`default_nettype none
module rtc_countdown_timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [7:0] s_araddr,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic timer_irq
);
  logic [7:0] last_ar;
  logic unmapped;
  // the read answer is judged against the address that was taken
  always_ff @(posedge aclk) begin
    if (!aresetn) last_ar <= 8'h00;
    else if (s_arvalid && s_arready) last_ar <= s_araddr;
  end
  assign unmapped = (last_ar < 8'h1c) || (last_ar > 8'h48) || (last_ar[1:0] != 2'b00);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_quiet; $rose(aresetn) |-> !timer_irq && !s_bvalid && !s_rvalid && s_awready; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
  property p_ctrl_reserved; s_rvalid && last_ar == 8'h30 |-> (s_rdata & ~32'h00001ff7) == 32'h0 && s_rresp == 2'b00; endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("control read shows reserved bits");
  property p_clear_reads_zero; s_rvalid && last_ar == 8'h28 |-> s_rdata == 32'h0; endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read not zero");
  property p_unmapped_err; s_rvalid && unmapped |-> s_rresp == 2'b10; endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped read not refused");
  property p_bvalid_hold; s_bvalid && !s_bready |=> s_bvalid; endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
  property p_ready_low; s_bvalid |-> !s_awready && !s_wready; endproperty
  a_ready_low: assert property (p_ready_low) else $error("write channel open during response");
  property p_rvalid_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data not held");
  property p_read_answer; s_arvalid && s_arready |=> s_rvalid && !s_arready; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");
  property p_write_answer; s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered in time");
  c_irq: cover property ($rose(timer_irq));
  c_unmapped: cover property (s_rvalid && unmapped);
  c_write: cover property (s_bvalid && s_bready);
endmodule : rtc_countdown_timer_checker
`default_nettype wire

// ### verif/rtc_countdown_timer_tb.sv
// testbench: register access, periodic, one-shot, stop, clock select and self-start of the countdown timer
`timescale 1ns/1ps
`default_nettype none
module rtc_countdown_timer_tb;
  logic aclk = 1'b0, aresetn = 1'b0, slow_tick = 1'b0, trim_tick = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'd42715, v, l1, l2, pat;
  logic awready, wready, bvalid, arready, rvalid, timer_irq, timer_clk_en;
  logic [1:0] bresp, rresp, r;
  int n_mismatch = 0, checks_done = 0, iv1, iv2, n;
  rtc_countdown_timer dut_u (.aclk(aclk), .aresetn(aresetn), .slow_tick(slow_tick), .trim_tick(trim_tick),
    .s_awvalid(awvalid), .s_awready(awready), .s_awaddr(awaddr), .s_wvalid(wvalid), .s_wready(wready),
    .s_wdata(wdata), .s_wstrb(4'hf), .s_bvalid(bvalid), .s_bready(bready), .s_bresp(bresp),
    .s_arvalid(arvalid), .s_arready(arready), .s_araddr(araddr), .s_rvalid(rvalid), .s_rready(rready),
    .s_rdata(rdata), .s_rresp(rresp), .timer_irq(timer_irq), .timer_clk_en(timer_clk_en));
  always #2.5 aclk = ~aclk;
  // xorshift keeps the random draws repeatable
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic results();
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    @(posedge aclk);
    if (k == 50) begin
      n_mismatch++;
      results();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    if (k == 50) begin
      n_mismatch++;
      results();
    end
  endtask : rd
  task automatic tk(input bit t);
    if (t) trim_tick <= 1'b1;
    else slow_tick <= 1'b1;
    @(posedge aclk);
    slow_tick <= 1'b0;
    trim_tick <= 1'b0;
    @(posedge aclk);
  endtask : tk
  // ticks until the raw status shows the zero event; n is 0 when none came
  task automatic wait_evt(input bit t, input logic m, output int nt);
    int i;
    nt = 0;
    for (i = 1; i <= 30 && nt == 0; i++) begin
      tk(t);
      rd(8'h20, v, r);
      if (v[1] === 1'b1) nt = i;
    end
    if (nt != 0) begin
      chk({31'h0, timer_irq}, {31'h0, m});
      wr(8'h28, 32'h2);
      rd(8'h20, v, r);
      chk(v, 32'h0);
    end
  endtask : wait_evt
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v, r);
    chk(v, e);
  endtask : rdchk
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(8'h2c, 32'h0fffffff);
    rdchk(8'h30, 32'h0);
    rdchk(8'h34, 32'h0);
    rdchk(8'h38, 32'h0);
    rd(8'h50, v, r);
    chk({30'h0, r}, 32'h2);
    wr(8'h2c, 32'h0);
    chk({30'h0, bresp}, 32'h2);
    rdchk(8'h2c, 32'h0fffffff);
    l1 = (xs() % 4) + 2;
    l2 = l1 + 3;
    pat = xs();
    wr(8'h40, pat);
    chk({30'h0, bresp}, 32'h0);
    rdchk(8'h40, pat);
    wr(8'h34, l1);
    rdchk(8'h30, 32'h2);
    rdchk(8'h2c, l1);
    rdchk(8'h34, l1);
    wr(8'h38, l2);
    rdchk(8'h38, l2);
    // periodic with a two-bit pattern 0b10 alternating the load values
    wr(8'h3c, 32'h2);
    wr(8'h30, 32'h22);
    wait_evt(1'b0, 1'b0, n);
    chk(n != 0, 1);
    wr(8'h1c, 32'h2);
    wait_evt(1'b0, 1'b1, iv1);
    wait_evt(1'b0, 1'b1, iv2);
    chk(iv1 + iv2, l1 + l2 + 2);
    chk(iv1 != iv2, 1);
    wr(8'h30, 32'h20);
    wait_evt(1'b0, 1'b1, n);
    chk(n, 0);
    wr(8'h30, 32'h22);
    wait_evt(1'b0, 1'b1, n);
    chk(n != 0 && n <= l2 + 1, 1);
    chk(n, l1 + 1);
    // only the selected clock source advances the count
    wait_evt(1'b1, 1'b1, n);
    chk(n, 0);
    wr(8'h30, 32'h822);
    wait_evt(1'b1, 1'b1, n);
    chk(n != 0, 1);
    wr(8'h30, 32'h23);
    wait_evt(1'b0, 1'b1, n);
    chk(n != 0, 1);
    rdchk(8'h30, 32'h21);
    wait_evt(1'b0, 1'b1, n);
    chk(n, 0);
    wr(8'h30, 32'h24);
    wr(8'h3c, 32'h1);
    rdchk(8'h30, 32'h26);
    wr(8'h30, 32'h1000);
    repeat (3) @(posedge aclk);
    chk({31'h0, timer_clk_en}, 32'h1);
    wr(8'h30, 32'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, timer_clk_en}, 32'h0);
    results();
  end
endmodule : rtc_countdown_timer_tb
bind rtc_countdown_timer rtc_countdown_timer_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready),
  .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
  .s_rresp(s_rresp), .timer_irq(timer_irq));
`default_nettype wire
